//--- rtl/tmbx_core_if.sv
`timescale 1ns/1ps
interface tmbx_core_if;
  logic [1:0] tb_sel;
  logic restart;
  logic tick;
  logic edge_pol;
  logic trig_edge;
  modport core (output tb_sel, output restart, output edge_pol, input tick, input trig_edge);
  modport presc (input tb_sel, input restart, output tick);
  modport trig (input edge_pol, output trig_edge);
endinterface : tmbx_core_if

//--- rtl/tmbx_pkg.sv
package tmbx_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int TMBX_IDX_CTRL = 8'h38;
  localparam int TMBX_IDX_PRELOAD = 8'h39;
  localparam int TMBX_ADDR_W = 8;
  localparam logic [TMBX_ADDR_W-1:0] TMBX_ADDR_CTRL = TMBX_ADDR_W'(TMBX_IDX_CTRL * 4);
  localparam logic [TMBX_ADDR_W-1:0] TMBX_ADDR_PRELOAD = TMBX_ADDR_W'(TMBX_IDX_PRELOAD * 4);

  // ----------------------------------------------------------------
  // Control/status field positions
  // ----------------------------------------------------------------
  localparam int TMBX_BIT_TB_LO = 6;
  localparam int TMBX_BIT_OVF = 5;
  localparam int TMBX_BIT_OVERFLOW_IRQ_ENABLE = 4;
  localparam int TMBX_BIT_TAR = 3;
  localparam int TMBX_BIT_EXT = 2;
  localparam int TMBX_BIT_EDG = 1;
  localparam int TMBX_BIT_EEF = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TMBX_CTRL_RST = 8'h00;
  localparam logic [7:0] TMBX_PRELOAD_RST = 8'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TMBX_CLK_PERIOD_NS = 40;
  localparam int TMBX_TB_BASE_NS = 16000;
  localparam int TMBX_BASE_CYCLES = (TMBX_TB_BASE_NS + TMBX_CLK_PERIOD_NS - 1) / TMBX_CLK_PERIOD_NS;
  localparam logic [4:0] TMBX_MULT_X1 = 5'h01;
  localparam logic [4:0] TMBX_MULT_X8 = 5'h08;
  localparam logic [4:0] TMBX_MULT_X16 = 5'h10;

  typedef enum logic [1:0] {
    TMBX_TB_X1,
    TMBX_TB_X8,
    TMBX_TB_X16,
    TMBX_TB_RSVD
  } tmbx_tb_t;

  // Number of base periods in one count period.
  function automatic logic [4:0] tmbx_mult(input logic [1:0] tb);
    unique case (tmbx_tb_t'(tb))
      TMBX_TB_X1: tmbx_mult = TMBX_MULT_X1;
      TMBX_TB_X8: tmbx_mult = TMBX_MULT_X8;
      TMBX_TB_X16: tmbx_mult = TMBX_MULT_X16;
      TMBX_TB_RSVD: tmbx_mult = TMBX_MULT_X16;
    endcase
  endfunction : tmbx_mult

endpackage : tmbx_pkg

//--- rtl/tmbx_prescale.sv
`timescale 1ns/1ps
module tmbx_prescale #(
  parameter int BASE_CYCLES = tmbx_pkg::TMBX_BASE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  tmbx_core_if.presc bus
);
  import tmbx_pkg::*;

  localparam int BW = (BASE_CYCLES > 1) ? $clog2(BASE_CYCLES) : 1;

  logic [BW-1:0] base_q, base_d;
  logic [3:0] mult_q, mult_d;
  logic base_wrap;
  logic [4:0] mult_now;

  // ----------------------------------------------------------------
  // Base period and multiplier counters
  // ----------------------------------------------------------------
  always_comb begin
    mult_now = tmbx_mult(bus.tb_sel);
    base_wrap = base_q == BW'(BASE_CYCLES - 1);
    bus.tick = base_wrap && ({1'b0, mult_q} >= (mult_now - 5'h01)) && !bus.restart;
    base_d = base_wrap ? '0 : base_q + BW'(1);
    mult_d = mult_q;
    if (base_wrap) begin
      mult_d = ({1'b0, mult_q} >= (mult_now - 5'h01)) ? 4'h0 : mult_q + 4'h1;
    end
    if (bus.restart) begin
      base_d = '0;
      mult_d = 4'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      base_q <= '0;
      mult_q <= 4'h0;
    end else begin
      base_q <= base_d;
      mult_q <= mult_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] gap_q;
  logic dirty_q;
  logic [1:0] tb_prev_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= 16'h0000;
      dirty_q <= 1'b1;
      tb_prev_q <= 2'h0;
    end else begin
      tb_prev_q <= bus.tb_sel;
      gap_q <= (bus.tick || bus.restart) ? 16'h0000 : gap_q + 16'h0001;
      dirty_q <= (bus.tick || bus.restart) ? 1'b0 : (dirty_q || (bus.tb_sel != tb_prev_q));
    end
  end

  property p_period;
    @(posedge ref_clk) disable iff (!rstn)
    bus.tick && !dirty_q && (bus.tb_sel == tb_prev_q) |-> gap_q == 16'(BASE_CYCLES * int'(mult_now) - 1);
  endproperty
  a_period: assert property (p_period) else $error("count period length wrong");

endmodule : tmbx_prescale

//--- rtl/tmbx_timer.sv
`timescale 1ns/1ps
// What this block does
// - Two-bit time base picks one, eight or sixteen base periods; code 11 reserved.
// - Counter counts down to 00h and loads on every preload register write.
// - With auto-reload set, counter reloads from preload each time it reaches 00h.
// - Overflow flag sets at 00h; interrupt while flag and enable both set.
// - Reading control/status clears overflow flag; writes never clear it.
// - Auto-reload clear: one-shot, stops at 00h, restarts on preload write.
// - External mode preloads but only the selected edge starts counting.
// - Polarity bit 0 selects rising edge, 1 selects falling edge.
// - Accepted edge sets event flag, preloads counter and starts countdown.
// - Edges during a running countdown are ignored until 00h.
// - No reload plus external: only first pulse starts; leave by changing mode.
// - Reload plus external: preload at 00h, then wait for next edge.
// - Event flag clears at 00h in external mode and on mode bit change.
// - Internal mode: edge sets event flag, never cleared by the counter.
// - Running count value is never readable.
// - Preload N gives a countdown of N plus one periods.
module tmbx_timer #(
  parameter int BASE_CYCLES = tmbx_pkg::TMBX_BASE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [tmbx_pkg::TMBX_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic trig_in,
  output logic irq
);
  import tmbx_pkg::*;

  if (BASE_CYCLES < 2) begin : g_chk
    $error("BASE_CYCLES must be at least 2");
  end

  typedef enum logic [1:0] {
    TMBX_IDLE,
    TMBX_ARMED,
    TMBX_RUN
  } tmbx_state_t;

  tmbx_core_if u_if ();

  tmbx_prescale #(.BASE_CYCLES(BASE_CYCLES)) u_presc (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .bus(u_if.presc)
  );

  tmbx_trig_sync u_trig (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .trig_in(trig_in),
    .bus(u_if.trig)
  );

  logic [1:0] tb_q, tb_d;
  logic ovf_q, ovf_d;
  logic overflow_irq_enable_q, overflow_irq_enable_d;
  logic tar_q, tar_d;
  logic ext_q, ext_d;
  logic edg_q, edg_d;
  logic eef_q, eef_d;
  logic [7:0] pre_q, pre_d;
  logic [7:0] cnt_q, cnt_d;
  tmbx_state_t st_q, st_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic irq_q, irq_d;
  logic restart;
  logic req, acc, wr_ctrl, wr_pre, rd_ctrl, terminal;
  logic [7:0] ctrl_view;

  assign u_if.tb_sel = tb_q;
  assign u_if.edge_pol = edg_q;
  assign u_if.restart = restart;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  always_comb begin
    req = avs_read || avs_write;
    acc = req && !wait_q;
    wr_ctrl = acc && avs_write && avs_byteenable[0] && (avs_address == TMBX_ADDR_CTRL);
    wr_pre = acc && avs_write && avs_byteenable[0] && (avs_address == TMBX_ADDR_PRELOAD);
    rd_ctrl = acc && avs_read && (avs_address == TMBX_ADDR_CTRL);
    terminal = (st_q == TMBX_RUN) && u_if.tick && (cnt_q == 8'h00);
    ctrl_view = {tb_q, ovf_q, overflow_irq_enable_q, tar_q, ext_q, edg_q, eef_q};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    tb_d = tb_q;
    ovf_d = ovf_q;
    overflow_irq_enable_d = overflow_irq_enable_q;
    tar_d = tar_q;
    ext_d = ext_q;
    edg_d = edg_q;
    eef_d = eef_q;
    pre_d = pre_q;
    cnt_d = cnt_q;
    st_d = st_q;
    restart = 1'b0;
    rdata_d = rdata_q;
    wait_d = !(req && wait_q);
    if (req && wait_q) begin
      if (avs_read && (avs_address == TMBX_ADDR_CTRL)) begin
        rdata_d = {24'h000000, ctrl_view};
      end else if (avs_read && (avs_address == TMBX_ADDR_PRELOAD)) begin
        rdata_d = {24'h000000, pre_q};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
    if (wr_ctrl) begin
      tb_d = avs_writedata[TMBX_BIT_TB_LO +: 2];
      overflow_irq_enable_d = avs_writedata[TMBX_BIT_OVERFLOW_IRQ_ENABLE];
      tar_d = avs_writedata[TMBX_BIT_TAR];
      ext_d = avs_writedata[TMBX_BIT_EXT];
      edg_d = avs_writedata[TMBX_BIT_EDG];
      if (avs_writedata[TMBX_BIT_EXT] != ext_q) begin
        eef_d = 1'b0;
        cnt_d = pre_q;
        restart = 1'b1;
        st_d = avs_writedata[TMBX_BIT_EXT] ? TMBX_ARMED : TMBX_IDLE;
      end
    end
    if (rd_ctrl && rdata_q[TMBX_BIT_OVF]) begin
      ovf_d = 1'b0;
    end
    if ((st_q == TMBX_RUN) && u_if.tick && (cnt_q != 8'h00)) begin
      cnt_d = cnt_q - 8'h01;
    end
    if (terminal) begin
      ovf_d = 1'b1;
      if (ext_q) begin
        eef_d = 1'b0;
      end
      unique case ({tar_q, ext_q})
        2'b10: begin
          cnt_d = pre_q;
          st_d = TMBX_RUN;
        end
        2'b11: begin
          cnt_d = pre_q;
          st_d = TMBX_ARMED;
        end
        default: begin
          st_d = TMBX_IDLE;
        end
      endcase
    end
    if (u_if.trig_edge) begin
      if (!ext_q) begin
        eef_d = 1'b1;
      end else if (st_q == TMBX_ARMED) begin
        eef_d = 1'b1;
        cnt_d = pre_q;
        st_d = TMBX_RUN;
        restart = 1'b1;
      end
    end
    if (wr_pre) begin
      pre_d = avs_writedata[7:0];
      cnt_d = avs_writedata[7:0];
      restart = 1'b1;
      st_d = ext_q ? TMBX_ARMED : TMBX_RUN;
    end
    irq_d = ovf_d && overflow_irq_enable_d;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tb_q <= TMBX_CTRL_RST[TMBX_BIT_TB_LO +: 2];
      ovf_q <= TMBX_CTRL_RST[TMBX_BIT_OVF];
      overflow_irq_enable_q <= TMBX_CTRL_RST[TMBX_BIT_OVERFLOW_IRQ_ENABLE];
      tar_q <= TMBX_CTRL_RST[TMBX_BIT_TAR];
      ext_q <= TMBX_CTRL_RST[TMBX_BIT_EXT];
      edg_q <= TMBX_CTRL_RST[TMBX_BIT_EDG];
      eef_q <= TMBX_CTRL_RST[TMBX_BIT_EEF];
      pre_q <= TMBX_PRELOAD_RST;
      cnt_q <= 8'h00;
      st_q <= TMBX_IDLE;
      rdata_q <= 32'h00000000;
      wait_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      tb_q <= tb_d;
      ovf_q <= ovf_d;
      overflow_irq_enable_q <= overflow_irq_enable_d;
      tar_q <= tar_d;
      ext_q <= ext_d;
      edg_q <= edg_d;
      eef_q <= eef_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      st_q <= st_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ovf_set;
    @(posedge ref_clk) disable iff (!rstn)
    terminal |=> ovf_q;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set at terminal count");

  property p_irq;
    @(posedge ref_clk) disable iff (!rstn)
    irq_q == (ovf_q && overflow_irq_enable_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt does not follow flag and enable");

  property p_ovf_rd_clear;
    @(posedge ref_clk) disable iff (!rstn)
    rd_ctrl && rdata_q[TMBX_BIT_OVF] && !terminal |=> !ovf_q;
  endproperty
  a_ovf_rd_clear: assert property (p_ovf_rd_clear) else $error("status read did not clear overflow");

  property p_ovf_wr_keep;
    @(posedge ref_clk) disable iff (!rstn)
    wr_ctrl && ovf_q |=> ovf_q;
  endproperty
  a_ovf_wr_keep: assert property (p_ovf_wr_keep) else $error("write cleared overflow flag");

  property p_preload_int;
    @(posedge ref_clk) disable iff (!rstn)
    wr_pre && !ext_q |=> (cnt_q == $past(avs_writedata[7:0])) && (st_q == TMBX_RUN) && (pre_q == cnt_q);
  endproperty
  a_preload_int: assert property (p_preload_int) else $error("preload write did not start countdown");

  property p_preload_ext;
    @(posedge ref_clk) disable iff (!rstn)
    wr_pre && ext_q |=> (st_q == TMBX_ARMED) ##1 (st_q != TMBX_RUN || $past(u_if.trig_edge));
  endproperty
  a_preload_ext: assert property (p_preload_ext) else $error("external mode started without edge");

  property p_reload;
    @(posedge ref_clk) disable iff (!rstn)
    terminal && tar_q && !ext_q && !acc |=> (cnt_q == pre_q) && (st_q == TMBX_RUN);
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload missing");

  property p_oneshot;
    @(posedge ref_clk) disable iff (!rstn)
    terminal && !tar_q && !acc |=> (st_q == TMBX_IDLE) ##1 (st_q == TMBX_IDLE || $past(acc));
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");

  property p_ext_start;
    @(posedge ref_clk) disable iff (!rstn)
    (st_q == TMBX_ARMED) && ext_q && u_if.trig_edge && !acc |=> eef_q && (st_q == TMBX_RUN) && (cnt_q == pre_q);
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("edge did not start countdown");

  property p_no_retrig;
    @(posedge ref_clk) disable iff (!rstn)
    (st_q == TMBX_RUN) && ext_q && u_if.trig_edge && !terminal && !acc |=> $stable(eef_q) && (st_q == TMBX_RUN);
  endproperty
  a_no_retrig: assert property (p_no_retrig) else $error("edge retriggered running countdown");

  property p_ext_wait;
    @(posedge ref_clk) disable iff (!rstn)
    terminal && tar_q && ext_q && !acc |=> (st_q == TMBX_ARMED) && (cnt_q == pre_q) && !eef_q;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("reload external mode did not rearm");

  property p_eef_mode;
    @(posedge ref_clk) disable iff (!rstn)
    wr_ctrl && (avs_writedata[TMBX_BIT_EXT] != ext_q) && !u_if.trig_edge |=> !eef_q;
  endproperty
  a_eef_mode: assert property (p_eef_mode) else $error("mode change did not clear event flag");

  property p_eef_int;
    @(posedge ref_clk) disable iff (!rstn)
    !ext_q && eef_q && !wr_ctrl |=> eef_q;
  endproperty
  a_eef_int: assert property (p_eef_int) else $error("internal mode cleared event flag");

  property p_waitreq;
    @(posedge ref_clk) disable iff (!rstn)
    req && wait_q |=> !wait_q ##1 wait_q;
  endproperty
  a_waitreq: assert property (p_waitreq) else $error("bus answer timing wrong");

  c_autoreload: cover property (@(posedge ref_clk) disable iff (!rstn) terminal && tar_q && !ext_q);
  c_ext_start: cover property (@(posedge ref_clk) disable iff (!rstn) (st_q == TMBX_ARMED) && u_if.trig_edge);
  c_rd_clear: cover property (@(posedge ref_clk) disable iff (!rstn) rd_ctrl && rdata_q[TMBX_BIT_OVF]);
  c_oneshot_ext: cover property (@(posedge ref_clk) disable iff (!rstn) terminal && !tar_q && ext_q);

endmodule : tmbx_timer

//--- rtl/tmbx_trig_sync.sv
`timescale 1ns/1ps
module tmbx_trig_sync (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic trig_in,
  tmbx_core_if.trig bus
);
  import tmbx_pkg::*;

  logic [2:0] sh_q, sh_d;

  // ----------------------------------------------------------------
  // Two-stage synchroniser plus one history stage
  // ----------------------------------------------------------------
  always_comb begin
    sh_d = {sh_q[1:0], trig_in};
    bus.trig_edge = bus.edge_pol ? (sh_q[2] && !sh_q[1]) : (!sh_q[2] && sh_q[1]);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sh_q <= 3'h0;
    end else begin
      sh_q <= sh_d;
    end
  end

  property p_edge;
    @(posedge ref_clk) disable iff (!rstn)
    bus.trig_edge |-> ($past(trig_in, 2) == !bus.edge_pol) && ($past(trig_in, 3) == bus.edge_pol);
  endproperty
  a_edge: assert property (p_edge) else $error("edge reported without matching input transition");

endmodule : tmbx_trig_sync

//--- tb/tmbx_timer_test.sv
`timescale 1ns/1ps
module tmbx_timer_test;
  import tmbx_pkg::*;
  localparam int BC = 4;
  localparam logic [7:0] CTL = TMBX_ADDR_CTRL;
  localparam logic [7:0] PRE = TMBX_ADDR_PRELOAD;
  logic ref_clk;
  logic rstn;
  logic [TMBX_ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic trig_in;
  logic irq;
  int bad_count;
  int n_checks;
  int ticks;
  int s;
  int at;

  tmbx_timer #(.BASE_CYCLES(BC)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trig_in(trig_in), .irq(irq));
  tmbx_trig_model u_trig (.ref_clk(ref_clk), .trig_in(trig_in));

  // --------------------------------
  // Clock, cycle count and run limit
  // --------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    ticks <= ticks + 1;
    if (ticks > 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk8

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= addr;
    avs_writedata <= {24'h000000, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    chk_rng("bus answer", 1, 49, n);
    if (!wr) begin
      chk8("readdata upper", 8'h00, avs_readdata[15:8] | avs_readdata[23:16] | avs_readdata[31:24]);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] addr, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, addr, d, r);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] r;
    bus(1'b0, addr, 8'h00, r);
    chk8(what, exp, r);
  endtask : rd_chk

  task automatic irq_at(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    at = (irq === 1'b1) ? ticks : -1;
  endtask : irq_at

  task automatic clr(input logic [7:0] exp);
    rd_chk("status read", CTL, exp);
    repeat (2) @(posedge ref_clk);
    chk8("irq after read", 8'h00, {7'h00, irq});
  endtask : clr

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset;
    rd_chk("ctrl reset", CTL, 8'h00);
    rd_chk("preload reset", PRE, 8'h01);
    rd_chk("unmapped", 8'h10, 8'h00);
    wr(CTL, 8'h3F);
    rd_chk("status bits", CTL, 8'h1E);
    wr(CTL, 8'h10);
    wr(8'h10, 8'hFF);
    avs_byteenable <= 4'hE;
    wr(PRE, 8'h55);
    avs_byteenable <= 4'h1;
    rd_chk("ctrl kept", CTL, 8'h10);
    rd_chk("preload kept", PRE, 8'h01);
  endtask : t_reset

  task automatic t_oneshot;
    wr(PRE, 8'h03);
    s = ticks;
    irq_at(100);
    chk_rng("one shot", 4 * BC, 4 * BC + 4, at - s);
    clr(8'h30);
    rd_chk("flag cleared", CTL, 8'h10);
    irq_at(100);
    chk_rng("stopped", -1, -1, at);
  endtask : t_oneshot

  task automatic t_timebase;
    logic [7:0] cv;
    int m;
    for (int c = 1; c < 3; c++) begin
      cv = {c[1:0], 6'h10};
      m = (c == 1) ? 8 : 16;
      wr(CTL, cv);
      wr(PRE, 8'h01);
      s = ticks;
      irq_at(40 * m);
      chk_rng("time base", 2 * BC * m, 2 * BC * m + 4, at - s);
      clr(cv | 8'h20);
    end
    wr(CTL, 8'h10);
  endtask : t_timebase

  task automatic t_reload;
    wr(CTL, 8'h18);
    wr(PRE, 8'h02);
    irq_at(60);
    s = at;
    clr(8'h38);
    irq_at(60);
    chk_rng("reload", 3 * BC - 1, 3 * BC + 2, at - s);
    wr(CTL, 8'h10);
    repeat (3 * BC + 4) @(posedge ref_clk);
    clr(8'h30);
  endtask : t_reload

  task automatic t_ext_rise;
    wr(CTL, 8'h14);
    wr(PRE, 8'h05);
    irq_at(40);
    chk_rng("no start on write", -1, -1, at);
    rd_chk("event idle", CTL, 8'h14);
    s = ticks;
    u_trig.set_level(1'b1, 3);
    rd_chk("event set", CTL, 8'h15);
    u_trig.set_level(1'b0, 2);
    u_trig.set_level(1'b1, 2);
    irq_at(60);
    chk_rng("external run", 6 * BC + 3, 6 * BC + 9, at - s);
    clr(8'h34);
    u_trig.set_level(1'b0, 2);
    u_trig.set_level(1'b1, 2);
    irq_at(60);
    chk_rng("second pulse", -1, -1, at);
  endtask : t_ext_rise

  task automatic t_ext_fall;
    u_trig.set_level(1'b0, 4);
    wr(CTL, 8'h1E);
    wr(PRE, 8'h01);
    for (int k = 0; k < 2; k++) begin
      u_trig.set_level(1'b1, 4);
      irq_at(40);
      chk_rng("wrong edge", -1, -1, at);
      s = ticks;
      u_trig.set_level(1'b0, 1);
      irq_at(60);
      chk_rng("falling start", 2 * BC + 3, 2 * BC + 9, at - s);
      clr(8'h3E);
    end
  endtask : t_ext_fall

  task automatic t_int_edge;
    wr(CTL, 8'h00);
    u_trig.set_level(1'b1, 5);
    rd_chk("edge seen", CTL, 8'h01);
    wr(PRE, 8'h01);
    repeat (2 * BC + 6) @(posedge ref_clk);
    chk8("irq masked", 8'h00, {7'h00, irq});
    rd_chk("flag kept", CTL, 8'h21);
    wr(CTL, 8'h04);
    rd_chk("event cleared", CTL, 8'h04);
  endtask : t_int_edge

  initial begin
    bad_count = 0;
    n_checks = 0;
    ticks = 0;
    rstn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_oneshot();
    t_timebase();
    t_reload();
    t_ext_rise();
    t_ext_fall();
    t_int_edge();
    end_of_test();
  end
endmodule : tmbx_timer_test

//--- tb/tmbx_trig_model.sv
`timescale 1ns/1ps
module tmbx_trig_model (
  input wire logic ref_clk,
  output logic trig_in
);
  // --------------------------------
  // Trigger pin source
  // --------------------------------
  initial begin
    trig_in = 1'b0;
  end

  // Moves the pin after a clock edge and holds the level for hold cycles.
  task automatic set_level(input logic level, input int hold);
    @(posedge ref_clk);
    trig_in <= level;
    repeat (hold) @(posedge ref_clk);
  endtask : set_level
endmodule : tmbx_trig_model
